// ### src/slcr_regs.sv
/*
  Per-channel loop configuration register bank of a three-channel solenoid
  driver, reached by 32-bit SPI frames. Read data for a frame is the data
  addressed by the previous frame. Assumes the period controller drives
  the per-channel turn-off level and a load pulse from outside.
  The clock enable freezes every flip-flop, the pin synchronisers too,
  so a frame that runs while it is low is lost to the bank. Channel code
  three and unknown register codes are dropped and answered with zero.
  Limits, gain and period are plain registers: the loop must tolerate a
  new value landing at any edge, as there is no shadow copy.
*/
// Summary of operation
// - Bit 31 write flag; reads return zero there
// - Upper clamp 23:12, reset 7ff, times 32
// - Lower clamp 11:0, reset 7ff, minus 32
// - Gain exponent 22:20, seven stored as six
// - Gain exponent resets to two, quarter
// - Period 11:0, sixteen clocks per count
// - Read-only turn-off level 21:6, resets zero
// - Open-load threshold 5:0, resets zero
// - Open-load detection enabled only when nonzero
module slcr_regs
  import slcr_pkg::*;
#(
  parameter int NCH = NUM_CHAN
)(
  input  wire logic                          sys_clk,
  input  wire logic                          resetn,
  input  wire logic                          clk_en,
  input  wire logic                          spi_sck,
  input  wire logic                          spi_csn,
  input  wire logic                          spi_mosi,
  output logic                               spi_miso,
  input  wire logic [NCH-1:0]                thresh_load,
  input  wire logic [NCH*THRESH_W-1:0]       thresh_value,
  output logic [NCH*18-1:0]                  upper_limit,
  output logic [NCH*18-1:0]                  lower_limit,
  output logic [NCH*GAIN_W-1:0]              integral_gain_exponent,
  output logic [NCH*16-1:0]                  period_sys_clocks,
  output logic [NCH*OPEN_W-1:0]              open_load_threshold,
  output logic [NCH-1:0]                     open_load_enable
);

  // ******************************************************************
  // Frame shifter
  // ******************************************************************
  logic [FRAME_W-1:0] rx_word;
  logic [FRAME_W-1:0] tx_word;
  logic               frame_done;

  slcr_spi_shift u_shift (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .clk_en      (clk_en),
    .spi_sck     (spi_sck),
    .spi_csn     (spi_csn),
    .spi_mosi    (spi_mosi),
    .tx_word     (tx_word),
    .spi_miso    (spi_miso),
    .frame_start (),
    .frame_done  (frame_done),
    .rx_word     (rx_word)
  );

  // ******************************************************************
  // Frame decode
  // ******************************************************************
  logic       is_write;
  logic [3:0] code;
  logic [1:0] chan;
  logic       chan_ok;

  assign is_write = rx_word[RW_BIT];
  assign code     = rx_word[CODE_HI:CODE_LO];
  assign chan     = rx_word[CHAN_HI:CHAN_LO];
  assign chan_ok  = (32'(chan) < NCH);

  // ******************************************************************
  // Accepted frames
  // ******************************************************************
  // Strobes live for the one edge after a full frame. A frame aimed at
  // a channel that does not exist is dropped here, so storage never
  // sees it, and the reply it leaves for the next frame is all zero.
  logic rd_accept;
  logic wr_limits;
  logic wr_period;
  logic wr_thresh;

  assign rd_accept = frame_done & chan_ok;
  assign wr_limits = rd_accept & is_write & (code == CODE_LIMITS);
  assign wr_period = rd_accept & is_write & (code == CODE_PERIOD);
  assign wr_thresh = rd_accept & is_write & (code == CODE_THRESH);

  // ******************************************************************
  // Per-channel storage
  // ******************************************************************
  logic [LIM_W-1:0]    high_lim  [NCH];
  logic [LIM_W-1:0]    low_lim   [NCH];
  logic [GAIN_W-1:0]   gain      [NCH];
  logic [PERIOD_W-1:0] period    [NCH];
  logic [THRESH_W-1:0] thresh    [NCH];
  logic [OPEN_W-1:0]   open_lim  [NCH];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      logic                sel;
      logic [LIM_W-1:0]    next_high;
      logic [LIM_W-1:0]    next_low;
      logic [GAIN_W-1:0]   next_gain;
      logic [PERIOD_W-1:0] next_period;
      logic [THRESH_W-1:0] next_thresh;
      logic [OPEN_W-1:0]   next_open;
      logic [GAIN_W-1:0]   wr_gain;

      // Write decode for this channel
      always_comb begin
        sel         = (32'(chan) == g);
        next_high   = high_lim[g];
        next_low    = low_lim[g];
        next_gain   = gain[g];
        next_period = period[g];
        next_open   = open_lim[g];
        next_thresh = thresh[g];
        wr_gain     = rx_word[GAIN_LO +: GAIN_W];
        if (sel && wr_limits) begin
          next_high = rx_word[HIGH_LIM_LO +: LIM_W];
          next_low  = rx_word[LOW_LIM_LO +: LIM_W];
        end
        if (sel && wr_period) begin
          // Seven is out of range and saturates
          next_gain   = (wr_gain > GAIN_MAX) ? GAIN_MAX : wr_gain;
          next_period = rx_word[PERIOD_LO +: PERIOD_W];
        end
        if (sel && wr_thresh) begin
          next_open = rx_word[OPEN_LO +: OPEN_W];
        end
        // Controller owns the level; software cannot write it
        if (thresh_load[g]) begin
          next_thresh = thresh_value[g*THRESH_W +: THRESH_W];
        end
      end

      // Storage registers
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          high_lim[g] <= RST_LIMIT;
          low_lim[g]  <= RST_LIMIT;
          gain[g]     <= RST_GAIN;
          period[g]   <= RST_PERIOD;
          thresh[g]   <= RST_THRESH;
          open_lim[g] <= RST_OPEN;
        end else if (clk_en) begin
          high_lim[g] <= next_high;
          low_lim[g]  <= next_low;
          gain[g]     <= next_gain;
          period[g]   <= next_period;
          thresh[g]   <= next_thresh;
          open_lim[g] <= next_open;
        end
      end

      // Scaled values for the loop; combinational from the registers,
      // so they move one edge after a write, never in mid-frame
      assign upper_limit[g*18 +: 18] = {1'b0, high_lim[g], 5'h00};
      assign lower_limit[g*18 +: 18] = 18'(-{1'b0, low_lim[g], 5'h00});
      assign integral_gain_exponent[g*GAIN_W +: GAIN_W] = gain[g];
      assign period_sys_clocks[g*16 +: 16] = {period[g], 4'h0};
      assign open_load_threshold[g*OPEN_W +: OPEN_W] = open_lim[g];
      assign open_load_enable[g] = (open_lim[g] != RST_OPEN);
    end
  endgenerate

  // ******************************************************************
  // Read-back capture for the next frame
  // ******************************************************************
  logic [FRAME_W-1:0] next_tx;

  // Channel loop rather than an indexed read: channel code three has no
  // storage behind it, so an index would run past the arrays
  always_comb begin
    next_tx = tx_word;
    if (frame_done) begin
      next_tx = '0;
    end
    for (int k = 0; k < NCH; k++) begin
      if (rd_accept && (32'(chan) == k)) begin
        next_tx[CODE_HI:CODE_LO] = code;
        next_tx[CHAN_HI:CHAN_LO] = chan;
        unique case (code)
          CODE_LIMITS: begin
            next_tx[HIGH_LIM_LO +: LIM_W] = high_lim[k];
            next_tx[LOW_LIM_LO +: LIM_W]  = low_lim[k];
          end
          CODE_PERIOD: begin
            next_tx[GAIN_LO +: GAIN_W]     = gain[k];
            next_tx[PERIOD_LO +: PERIOD_W] = period[k];
          end
          CODE_THRESH: begin
            next_tx[THRESH_LO +: THRESH_W] = thresh[k];
            next_tx[OPEN_LO +: OPEN_W]     = open_lim[k];
          end
          default: next_tx = '0;
        endcase
      end
    end
  end

  // Write data lands the same edge, so read-back shows old contents;
  // the reply then stands until the next full frame ends, channel three too
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_word <= '0;
    end else if (clk_en) begin
      tx_word <= next_tx;
    end
  end

endmodule // slcr_regs

// ### src/slcr_pkg.sv
/*
  Package for the solenoid loop configuration register bank: frame layout,
  register codes, field positions and reset values.
  Assumes a 32-bit SPI frame, MSB first, mode 0, from an external master.
*/
package slcr_pkg;

  // ******************************************************************
  // Frame layout
  // ******************************************************************
  localparam int FRAME_W      = 32;
  localparam int RW_BIT       = 31;
  localparam int CODE_HI      = 30;
  localparam int CODE_LO      = 27;
  localparam int CHAN_HI      = 25;
  localparam int CHAN_LO      = 24;
  localparam int NUM_CHAN     = 3;

  // Register codes in bits 30:27
  localparam logic [3:0] CODE_LIMITS = 4'h4;
  localparam logic [3:0] CODE_PERIOD = 4'h5;
  localparam logic [3:0] CODE_THRESH = 4'h6;

  // ******************************************************************
  // Field positions and widths
  // ******************************************************************
  localparam int HIGH_LIM_LO  = 12;
  localparam int LOW_LIM_LO   = 0;
  localparam int LIM_W        = 12;
  localparam int GAIN_LO      = 20;
  localparam int GAIN_W       = 3;
  localparam int PERIOD_LO    = 0;
  localparam int PERIOD_W     = 12;
  localparam int THRESH_LO    = 6;
  localparam int THRESH_W     = 16;
  localparam int OPEN_LO      = 0;
  localparam int OPEN_W       = 6;
  localparam int LIM_SCALE_SH = 5;   // Times 32
  localparam int PERIOD_TICKS = 16;  // System clocks per period count

  // ******************************************************************
  // Values after reset
  // ******************************************************************
  localparam logic [11:0] RST_LIMIT    = 12'h7ff;
  localparam logic [2:0]  RST_GAIN     = 3'h2;
  localparam logic [2:0]  GAIN_MAX     = 3'h6;
  localparam logic [11:0] RST_PERIOD   = 12'h000;
  localparam logic [15:0] RST_THRESH   = 16'h0000;
  localparam logic [5:0]  RST_OPEN     = 6'h00;

  // Clock
  localparam int SYS_CLK_HZ = 40000000;

endpackage : slcr_pkg

// ### src/slcr_spi_shift.sv
/*
  SPI slave shifter: synchronises the pins, shifts a 32-bit frame in on
  rising SCK and out on falling SCK, and pulses frame_done at CSN rise if the 6-bit count reads 32.
  Assumes SCK is much slower than sys_clk (at least 4 clocks per half).
*/
module slcr_spi_shift
  import slcr_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  input  wire logic                 spi_sck,
  input  wire logic                 spi_csn,
  input  wire logic                 spi_mosi,
  input  wire logic [FRAME_W-1:0]   tx_word,
  output logic                      spi_miso,
  output logic                      frame_start,
  output logic                      frame_done,
  output logic [FRAME_W-1:0]        rx_word
);

  // ******************************************************************
  // Two-stage synchronisers
  // ******************************************************************
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] next_sync1;
  logic [2:0] next_sync2;
  logic       sck_d;
  logic       csn_d;
  logic       next_sck_d;
  logic       next_csn_d;
  logic [FRAME_W-1:0] shreg;
  logic [FRAME_W-1:0] next_shreg;
  logic [5:0]         cnt;
  logic [5:0]         next_cnt;
  logic               next_miso;
  logic               next_start;
  logic               next_done;
  logic [FRAME_W-1:0] next_rx;
  logic               sck_rise;
  logic               sck_fall;

  // Edge detection reads only the second stage
  always_comb begin
    next_sync1 = {spi_sck, spi_csn, spi_mosi};
    next_sync2 = sync1;
    next_sck_d = sync2[2];
    next_csn_d = sync2[1];
    sck_rise   = sync2[2] & ~sck_d;
    sck_fall   = ~sync2[2] & sck_d;
    next_shreg = shreg;
    next_cnt   = cnt;
    next_miso  = spi_miso;
    next_start = 1'b0;
    next_done  = 1'b0;
    next_rx    = rx_word;
    if (csn_d & ~sync2[1]) begin
      // Frame opens: load reply, first bit out at once
      next_start = 1'b1;
      next_cnt   = 6'h00;
      next_shreg = tx_word;
      next_miso  = tx_word[FRAME_W-1];
    end else if (~sync2[1]) begin
      if (sck_rise) begin
        next_shreg = {shreg[FRAME_W-2:0], sync2[0]};
        next_cnt   = cnt + 6'h01;
      end else if (sck_fall) begin
        next_miso  = shreg[FRAME_W-1];
      end
    end else if (~csn_d & sync2[1]) begin
      // Short frames are dropped; long ones too, unless the 6-bit count wraps back to 32
      next_done = (cnt == 6'(FRAME_W));
      next_rx   = shreg;
      next_miso = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1       <= 3'h2;
      sync2       <= 3'h2;
      sck_d       <= 1'b0;
      csn_d       <= 1'b1;
      shreg       <= '0;
      cnt         <= 6'h00;
      spi_miso    <= 1'b0;
      frame_start <= 1'b0;
      frame_done  <= 1'b0;
      rx_word     <= '0;
    end else if (clk_en) begin
      sync1       <= next_sync1;
      sync2       <= next_sync2;
      sck_d       <= next_sck_d;
      csn_d       <= next_csn_d;
      shreg       <= next_shreg;
      cnt         <= next_cnt;
      spi_miso    <= next_miso;
      frame_start <= next_start;
      frame_done  <= next_done;
      rx_word     <= next_rx;
    end
  end

endmodule // slcr_spi_shift

// ### dv/slcr_host.sv
/*
  Host model: SPI master in mode 0, MSB first, 200 ns SCK period.
  Assumes the bench calls xfer just after a sys_clk rising edge.
*/
module slcr_host (
  input  wire logic sys_clk,
  input  wire logic spi_miso,
  output logic      spi_sck,
  output logic      spi_csn,
  output logic      spi_mosi
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus: clock still and low, no device selected
  initial begin
    spi_sck  = 1'b0;
    spi_csn  = 1'b1;
    spi_mosi = 1'b0;
  end
  // Half an SCK period is four sys_clk cycles
  task automatic half();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // Frame of n bits; reply bit taken as SCK rises
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = '0;
    spi_csn = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_mosi = w[31-i];
      half();
      spi_sck = 1'b1;
      r = {r[30:0], spi_miso};
      half();
      spi_sck = 1'b0;
    end
    half();
    spi_csn = 1'b1;
    spi_mosi = ~spi_mosi; // Released line must not echo the last bit
    repeat (8) half();
  endtask
endmodule // slcr_host

// ### dv/slcr_regs_chk.sv
/*
  Port assertions for slcr_regs, attached by bind.
  Assumes one sys_clk domain with async active-low reset.
*/
module slcr_regs_chk
  import slcr_pkg::*;
#(
  parameter int NCH = NUM_CHAN
)(
  input wire logic                    sys_clk,
  input wire logic                    resetn,
  input wire logic                    spi_csn,
  input wire logic                    spi_miso,
  input wire logic [NCH*18-1:0]       upper_limit,
  input wire logic [NCH*18-1:0]       lower_limit,
  input wire logic [NCH*GAIN_W-1:0]   integral_gain_exponent,
  input wire logic [NCH*16-1:0]       period_sys_clocks,
  input wire logic [NCH*OPEN_W-1:0]   open_load_threshold,
  input wire logic [NCH-1:0]          open_load_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [NCH*61-1:0] fields;
  // All SPI-written fields at the ports in one word
  assign fields = {upper_limit, lower_limit, integral_gain_exponent, period_sys_clocks, open_load_threshold};
  // Long select low: earlier frame settled
  sequence s_in_frame;
    (!spi_csn) [*8];
  endsequence
  sequence s_idle;
    spi_csn [*6];
  endsequence
  a_fields_hold: assert property (s_in_frame |-> $stable(fields))
    else $error("field moved in frame");
  a_change_gap: assert property ($changed(fields) |-> spi_csn && $past(spi_csn, 3))
    else $error("field moved early");
  a_miso_idle: assert property (s_idle |-> !spi_miso) else $error("miso busy outside frame");
  a_reset_vals: assert property ($rose(resetn) |-> integral_gain_exponent == {NCH{3'h2}}
    && upper_limit == {NCH{18'h0ffe0}} && lower_limit == {NCH{18'h30020}}
    && period_sys_clocks == 0 && open_load_enable == 0) else $error("bad reset");
  // Per channel scaling and range
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    a_gain_max: assert property (integral_gain_exponent[c*3 +: 3] <= GAIN_MAX) else $error("gain over six");
    a_open_enable: assert property (open_load_enable[c] == (open_load_threshold[c*6 +: 6] != 0))
      else $error("open en");
    a_upper_scale: assert property (upper_limit[c*18 +: 5] == 0 && !upper_limit[c*18+17])
      else $error("upper");
    a_lower_sign: assert property (lower_limit[c*18 +: 5] == 0
      && (lower_limit[c*18+17] || lower_limit[c*18 +: 18] == 0)) else $error("lower");
    a_period_scale: assert property (period_sys_clocks[c*16 +: 4] == 0) else $error("period");
  end
endmodule // slcr_regs_chk
bind slcr_regs slcr_regs_chk #(.NCH(NCH)) u_chk (.sys_clk(sys_clk), .resetn(resetn), .spi_csn(spi_csn),
  .spi_miso(spi_miso), .upper_limit(upper_limit), .lower_limit(lower_limit),
  .integral_gain_exponent(integral_gain_exponent), .period_sys_clocks(period_sys_clocks),
  .open_load_threshold(open_load_threshold), .open_load_enable(open_load_enable));

// ### dv/slcr_regs_tb.sv
/*
  Self-checking bench for slcr_regs: table of writes, then awkward cases.
  Assumes reply of a frame arrives in the frame after it.
*/
module slcr_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import slcr_pkg::*;
  typedef struct {logic [31:0] w, rb;} slcr_row_t;
  logic        sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
  logic        spi_sck, spi_csn, spi_mosi, spi_miso;
  logic [2:0]  thresh_load = '0, open_en;
  logic [47:0] thresh_value = '0, period;
  logic [53:0] upper_limit, lower_limit;
  logic [8:0]  gain;
  logic [17:0] open_thr;
  logic [31:0] r;
  int          n_fail = 0, compares = 0;
  logic [31:0] rst_w [3] = '{32'h207ff7ff, 32'h28200000, 32'h30000000};
  slcr_row_t   rows [7] = '{'{32'ha0123456, 32'h20123456}, '{32'ha2fff001, 32'h22fff001},
    '{32'ha9700fff, 32'h29600fff}, '{32'ha8000001, 32'h28000001}, '{32'hb13fffff, 32'h3100003f},
    '{32'hb2000001, 32'h32000001}, '{32'hb2000000, 32'h32000000}};
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  slcr_regs #(.NCH(3)) uut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .spi_sck(spi_sck),
    .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .thresh_load(thresh_load),
    .thresh_value(thresh_value), .upper_limit(upper_limit), .lower_limit(lower_limit),
    .integral_gain_exponent(gain), .period_sys_clocks(period), .open_load_threshold(open_thr),
    .open_load_enable(open_en));
  slcr_host host (.sys_clk(sys_clk), .spi_miso(spi_miso), .spi_sck(spi_sck), .spi_csn(spi_csn),
    .spi_mosi(spi_mosi));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Query twice: the second frame carries the first one's reply
  task automatic rd(input logic [31:0] q, output logic [31:0] d);
    host.xfer(q, 32, d);
    host.xfer(q, 32, d);
  endtask
  // Ports of the channel named in a stored word
  task automatic ports(input logic [31:0] rb);
    int c;
    c = rb[25:24];
    case (rb[30:27])
      CODE_LIMITS: begin
        chk("upper", {rb[23:12], 5'h0}, upper_limit[c*18 +: 18]);
        chk("lower", 18'(18'h0 - {rb[11:0], 5'h0}), lower_limit[c*18 +: 18]);
      end
      CODE_PERIOD: begin
        chk("gain", rb[22:20], gain[c*3 +: 3]);
        chk("period", {rb[11:0], 4'h0}, period[c*16 +: 16]);
      end
      default: begin
        chk("open", rb[5:0], open_thr[c*6 +: 6]);
        chk("enable", |rb[5:0], open_en[c]);
      end
    endcase
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    ports(32'h207ff7ff);
    foreach (rows[i]) begin
      host.xfer(rows[i].w, 32, r);
      ports(rows[i].rb);
      rd(rows[i].rb, r);
      chk("read back", rows[i].rb, r);
    end
    chk("ch1 upper", 18'h0ffe0, upper_limit[18 +: 18]);
    // Controller loads the turn-off level of channel 0 only
    thresh_value[15:0] = 16'habcd;
    thresh_load = 3'h1;
    @(posedge sys_clk);
    #1;
    thresh_load = 3'h0;
    rd(32'h30000000, r);
    chk("level", 32'h302af340, r);
    // Short frame, channel three and an unknown code must change nothing
    host.xfer(32'ha0fff000, 31, r);
    host.xfer(32'ha3fff000, 32, r);
    host.xfer(32'hb8fff000, 32, r);
    ports(32'h20123456);
    ports(32'h22fff001);
    rd(32'h23000000, r);
    chk("chan3 read", 32'h0, r);
    rd(32'h38000000, r);
    chk("code7 read", 32'h0, r);
    // A whole frame sent while the clock enable is low is never seen
    clk_en = 1'b0;
    host.xfer(32'ha0000000, 32, r);
    clk_en = 1'b1;
    ports(32'h20123456);
    // Mid-run reset, then every register of every channel
    resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    for (int c = 0; c < 3; c++) begin
      foreach (rst_w[k]) begin
        ports(rst_w[k] + (c << 24));
        rd(rst_w[k] + (c << 24), r);
        chk("reset read", rst_w[k] + (c << 24), r);
      end
    end
    results();
  end
  // About 14 k cycles expected; 1 ms means a hang
  initial begin
    #1ms;
    n_fail++;
    results();
  end
endmodule // slcr_regs_tb
